//--- src/sfr_mode_access_checker.sv
// Overview of operation
// - Boot mode reaches all groups but test, segmentation and banked CPU registers.
// - Test mode reaches all groups but segmentation and banked CPU registers.
// - Firmware mode reads firewall configuration, reads and writes firmware OS registers.
// - Firmware mode hardware register rights come from the two firewall controls, except that clock select reads are always granted.
// - System mode reaches segmentation, system management, firewall and hardware registers.
// - User mode hardware access follows the executing segment's table entry rights.
// - Copy engine keeps the CPU mode latched at its start for all accesses.
// - Shared CPU general registers are accessible in every mode.
// - Banked CPU registers open in System and User mode only.
// - CPU control/status register is also readable in Firmware and User mode.
// - Firmware mode may always read the clock select register.
// - Segmentation registers, table base included, are denied outside System mode.
// - The secondary protection register is never readable.
// - Writes to the random number output register are always refused.
// - Block cipher key registers are never readable.
// - Reset clears the segment table address to zero.
// - EEPROM integrity writes see all EEPROM; other firmware only its area.
// - Every denied access raises an exception.
// - Every access is checked against the mode before it takes effect.
`timescale 1ns/100ps
`default_nettype none
module sfr_mode_access_checker
   import smac_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            nrst,
   input  wire smac_mode_type   cpuMode,
   input  wire logic            cpuReq,
   input  wire logic            cpuWr,
   input  wire logic [7:0]      cpuAddr,
   input  wire logic [7:0]      cpuWdata,
   output logic                 cpuFault,
   output logic                 cpuRdValid,
   output logic [7:0]           cpuRdata,
   input  wire logic            dmaStart,
   input  wire logic            dmaStop,
   input  wire logic            dmaReq,
   input  wire logic            dmaWr,
   input  wire logic [7:0]      dmaAddr,
   input  wire logic [7:0]      dmaWdata,
   output logic                 dmaGnt,
   output logic                 dmaFault,
   output logic                 dmaRdValid,
   output logic [7:0]           dmaRdata,
   output logic                 dmaBusy,
   output smac_mode_type        dmaMode,
   input  wire logic [7:0]      segRdRights,
   input  wire logic [7:0]      segWrRights,
   output logic                 sfrEn,
   output logic                 sfrWr,
   output logic [7:0]           sfrAddr,
   output logic [7:0]           sfrWdata,
   input  wire logic [7:0]      sfrRdata,
   output logic [15:0]          segTableBase,
   output logic [7:0]           fwFirewallCtrlLow,
   output logic [7:0]           fwFirewallCtrlHigh,
   input  wire logic            eeIntegrityFn,
   input  wire logic            eeWriteActive,
   output logic                 eeWholeAccess,
   output logic                 eeFwAreaOnly,
   output logic                 faultValid,
   output logic [7:0]           faultAddr,
   output logic                 faultWr,
   output logic                 faultFromDma,
   output smac_mode_type        faultMode,
   input  wire logic            faultClear
);

   // State of the copy engine
   logic          dmaBusy_reg;
   logic          dmaBusy_next;
   smac_mode_type dmaMode_reg;
   smac_mode_type dmaMode_next;

   // Registers held inside this block
   logic [7:0]    segBaseLo_reg;
   logic [7:0]    segBaseHi_reg;
   logic [7:0]    fwCtrlLo_reg;
   logic [7:0]    fwCtrlHi_reg;

   // Read return registers
   logic          cpuRdValid_reg;
   logic [7:0]    cpuRdata_reg;
   logic          dmaRdValid_reg;
   logic [7:0]    dmaRdata_reg;

   // Fault record
   logic          faultValid_reg;
   logic          faultValid_next;
   logic [7:0]    faultAddr_reg;
   logic          faultWr_reg;
   logic          faultDma_reg;
   smac_mode_type faultMode_reg;

   // Decision and selection nets
   logic          cpuAllow;
   logic          dmaAllow;
   logic          dmaTake;
   logic          selGo;
   logic          selWr;
   logic [7:0]    selAddr;
   logic [7:0]    selWdata;
   logic          selAllow;
   logic          selDone;
   logic          anyFault;
   logic          isLocal;
   logic          wrSegLo, wrSegHi, wrFwLo, wrFwHi;
   logic [7:0]    localRd;
   logic [7:0]    rdValue;
   logic          fwNow;

   // Check of the CPU access in the current mode
   smac_rule_eval u_cpu_eval (
      .mode        (cpuMode),
      .isWr        (cpuWr),
      .addr        (cpuAddr),
      .fwRdRights  (fwCtrlLo_reg),
      .fwWrRights  (fwCtrlHi_reg),
      .segRdRights (segRdRights),
      .segWrRights (segWrRights),
      .allow       (cpuAllow)
   );

   // Check of the copy engine access in its latched mode
   smac_rule_eval u_dma_eval (
      .mode        (dmaMode_reg),
      .isWr        (dmaWr),
      .addr        (dmaAddr),
      .fwRdRights  (fwCtrlLo_reg),
      .fwWrRights  (fwCtrlHi_reg),
      .segRdRights (segRdRights),
      .segWrRights (segWrRights),
      .allow       (dmaAllow)
   );

   // Copy engine start latches the mode, start wins over stop
   assign dmaBusy_next = dmaStart | (dmaBusy_reg & ~dmaStop);
   assign dmaMode_next = dmaStart ? cpuMode : dmaMode_reg;

   // CPU has priority; copy engine runs only when started and CPU idle
   assign dmaTake = dmaReq & dmaBusy_reg & ~cpuReq;
   assign selGo    = cpuReq | dmaTake;
   assign selWr    = cpuReq ? cpuWr : dmaWr;
   assign selAddr  = cpuReq ? cpuAddr : dmaAddr;
   assign selWdata = cpuReq ? cpuWdata : dmaWdata;
   assign selAllow = cpuReq ? cpuAllow : dmaAllow;
   assign selDone  = selGo & selAllow;

   // Denied requests signal an exception in the same cycle
   assign cpuFault = cpuReq & ~cpuAllow;
   assign dmaFault = dmaTake & ~dmaAllow;
   assign dmaGnt   = dmaTake;
   assign anyFault = cpuFault | dmaFault;

   // Accesses to locally held registers
   assign isLocal = (selAddr == ADDR_SEG_BASE_LO) | (selAddr == ADDR_SEG_BASE_HI)
                  | (selAddr == ADDR_FW_CTRL_LO) | (selAddr == ADDR_FW_CTRL_HI);
   assign wrSegLo = selDone & selWr & (selAddr == ADDR_SEG_BASE_LO);
   assign wrSegHi = selDone & selWr & (selAddr == ADDR_SEG_BASE_HI);
   assign wrFwLo  = selDone & selWr & (selAddr == ADDR_FW_CTRL_LO);
   assign wrFwHi  = selDone & selWr & (selAddr == ADDR_FW_CTRL_HI);

   // Forward only granted accesses to the register file
   assign sfrEn    = selDone & ~isLocal;
   assign sfrWr    = selWr;
   assign sfrAddr  = selAddr;
   assign sfrWdata = selWdata;

   // Read value from local registers or the register file
   assign localRd = (selAddr == ADDR_SEG_BASE_LO) ? segBaseLo_reg :
                    (selAddr == ADDR_SEG_BASE_HI) ? segBaseHi_reg :
                    (selAddr == ADDR_FW_CTRL_LO)  ? fwCtrlLo_reg  :
                    (selAddr == ADDR_FW_CTRL_HI)  ? fwCtrlHi_reg  : RST_DATA;
   assign rdValue = ~selAllow ? RST_DATA :
                    isLocal   ? localRd  : sfrRdata;

   // Segment table base, cleared at reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         segBaseLo_reg <= RST_SEG_BASE;
         segBaseHi_reg <= RST_SEG_BASE;
      end else begin
         if (wrSegLo) segBaseLo_reg <= selWdata;
         if (wrSegHi) segBaseHi_reg <= selWdata;
      end
   end

   // Firmware firewall controls, no rights after reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         fwCtrlLo_reg <= RST_FW_CTRL;
         fwCtrlHi_reg <= RST_FW_CTRL;
      end else begin
         if (wrFwLo) fwCtrlLo_reg <= selWdata;
         if (wrFwHi) fwCtrlHi_reg <= selWdata;
      end
   end

   // Copy engine state
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dmaBusy_reg <= 1'b0;
         dmaMode_reg <= MODE_BOOT;
      end else begin
         dmaBusy_reg <= dmaBusy_next;
         dmaMode_reg <= dmaMode_next;
      end
   end

   // Read data back to the CPU one cycle after the request
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cpuRdValid_reg <= 1'b0;
         cpuRdata_reg   <= RST_DATA;
      end else begin
         cpuRdValid_reg <= cpuReq & ~cpuWr;
         if (cpuReq & ~cpuWr) cpuRdata_reg <= rdValue;
      end
   end

   // Read data back to the copy engine one cycle after the grant
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dmaRdValid_reg <= 1'b0;
         dmaRdata_reg   <= RST_DATA;
      end else begin
         dmaRdValid_reg <= dmaTake & ~dmaWr;
         if (dmaTake & ~dmaWr) dmaRdata_reg <= rdValue;
      end
   end

   // Fault record holds the first denied access until cleared
   assign faultValid_next = anyFault | (faultValid_reg & ~faultClear);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         faultValid_reg <= 1'b0;
      end else begin
         faultValid_reg <= faultValid_next;
      end
   end

   // Details of a new fault, taken only when none is held or a clear comes in the same cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         faultAddr_reg <= RST_DATA;
         faultWr_reg   <= 1'b0;
         faultDma_reg  <= 1'b0;
         faultMode_reg <= MODE_BOOT;
      end else if (anyFault & (~faultValid_reg | faultClear)) begin
         faultAddr_reg <= selAddr;
         faultWr_reg   <= selWr;
         faultDma_reg  <= ~cpuReq;
         faultMode_reg <= cpuReq ? cpuMode : dmaMode_reg;
      end
   end

   // EEPROM window for firmware code
   assign fwNow         = (cpuMode == MODE_FIRMWARE);
   assign eeWholeAccess = fwNow & eeIntegrityFn & eeWriteActive;
   assign eeFwAreaOnly  = fwNow & ~eeWholeAccess;

   // Outputs
   assign cpuRdValid         = cpuRdValid_reg;
   assign cpuRdata           = cpuRdata_reg;
   assign dmaRdValid         = dmaRdValid_reg;
   assign dmaRdata           = dmaRdata_reg;
   assign dmaBusy            = dmaBusy_reg;
   assign dmaMode            = dmaMode_reg;
   assign segTableBase       = {segBaseHi_reg, segBaseLo_reg};
   assign fwFirewallCtrlLow  = fwCtrlLo_reg;
   assign fwFirewallCtrlHigh = fwCtrlHi_reg;
   assign faultValid         = faultValid_reg;
   assign faultAddr          = faultAddr_reg;
   assign faultWr            = faultWr_reg;
   assign faultFromDma       = faultDma_reg;
   assign faultMode          = faultMode_reg;

endmodule : sfr_mode_access_checker
`default_nettype wire

//--- src/smac_pkg.sv
package smac_pkg;

   // CPU operating modes
   typedef enum logic [2:0] {
      MODE_BOOT     = 3'h0,
      MODE_TEST     = 3'h1,
      MODE_FIRMWARE = 3'h2,
      MODE_SYSTEM   = 3'h3,
      MODE_USER     = 3'h4
   } smac_mode_type;

   // Register groups, one per address page
   typedef enum logic [3:0] {
      GRP_CPU_SHARED = 4'h0,
      GRP_CPU_BANKED = 4'h1,
      GRP_TEST       = 4'h2,
      GRP_SEG_CFG    = 4'h3,
      GRP_SYS_MGMT   = 4'h4,
      GRP_FW_CFG     = 4'h5,
      GRP_FW_OS      = 4'h6,
      GRP_HW_COMP    = 4'h7,
      GRP_NONE       = 4'hF
   } smac_group_type;

   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int COMP_N = 8;

   // Field positions inside a register address
   localparam int PAGE_MSB = 7;
   localparam int PAGE_LSB = 4;
   localparam int COMP_MSB = 3;
   localparam int COMP_LSB = 1;

   // Register addresses
   localparam logic [7:0] ADDR_SEG_BASE_LO = 8'h30;
   localparam logic [7:0] ADDR_SEG_BASE_HI = 8'h31;
   localparam logic [7:0] ADDR_CPU_CONTROL_STATUS_REG     = 8'h40;
   localparam logic [7:0] ADDR_SEC_PROT    = 8'h41;
   localparam logic [7:0] ADDR_FW_CTRL_LO  = 8'h50;
   localparam logic [7:0] ADDR_FW_CTRL_HI  = 8'h51;
   localparam logic [7:0] ADDR_CLK_SEL     = 8'h70;
   localparam logic [7:0] ADDR_RNG_OUT     = 8'h72;
   localparam logic [7:0] ADDR_KEY_FIRST   = 8'h74;
   localparam logic [7:0] ADDR_KEY_LAST    = 8'h77;

   // Reset values
   localparam logic [7:0] RST_SEG_BASE = 8'h00;
   localparam logic [7:0] RST_FW_CTRL  = 8'h00;
   localparam logic [7:0] RST_DATA     = 8'h00;

   // Group of a register address
   function automatic smac_group_type smac_group_of(input logic [7:0] addr);
      logic [3:0] page;
      page = addr[PAGE_MSB:PAGE_LSB];
      if (page == 4'h0) smac_group_of = GRP_CPU_SHARED;
      else if (page == 4'h1) smac_group_of = GRP_CPU_BANKED;
      else if (page == 4'h2) smac_group_of = GRP_TEST;
      else if (page == 4'h3) smac_group_of = GRP_SEG_CFG;
      else if (page == 4'h4) smac_group_of = GRP_SYS_MGMT;
      else if (page == 4'h5) smac_group_of = GRP_FW_CFG;
      else if (page == 4'h6) smac_group_of = GRP_FW_OS;
      else if (page == 4'h7) smac_group_of = GRP_HW_COMP;
      else smac_group_of = GRP_NONE;
   endfunction : smac_group_of

   // Hardware component index of a register address
   function automatic logic [2:0] smac_comp_of(input logic [7:0] addr);
      smac_comp_of = addr[COMP_MSB:COMP_LSB];
   endfunction : smac_comp_of

endpackage : smac_pkg

//--- src/smac_rule_eval.sv
`timescale 1ns/100ps
`default_nettype none
module smac_rule_eval
   import smac_pkg::*;
(
   input  wire smac_mode_type   mode,
   input  wire logic            isWr,
   input  wire logic [7:0]      addr,
   input  wire logic [7:0]      fwRdRights,
   input  wire logic [7:0]      fwWrRights,
   input  wire logic [7:0]      segRdRights,
   input  wire logic [7:0]      segWrRights,
   output logic                 allow
);

   smac_group_type grp;
   logic [2:0]     comp;
   logic           isRd;
   logic           isShared, isBanked, isTest, isSeg, isSys;
   logic           isFwCfg, isFwOs, isHw, isNone;
   logic           isCsr, isSecProt, isClk, isRng, isKey;
   logic           fwHwOk, segHwOk;
   logic           bootOk, testOk, fwOk, sysOk, usrOk, modeOk, veto;

   // Classify the access
   assign grp       = smac_group_of(addr);
   assign comp      = smac_comp_of(addr);
   assign isRd      = ~isWr;
   assign isShared  = (grp == GRP_CPU_SHARED);
   assign isBanked  = (grp == GRP_CPU_BANKED);
   assign isTest    = (grp == GRP_TEST);
   assign isSeg     = (grp == GRP_SEG_CFG);
   assign isSys     = (grp == GRP_SYS_MGMT);
   assign isFwCfg   = (grp == GRP_FW_CFG);
   assign isFwOs    = (grp == GRP_FW_OS);
   assign isHw      = (grp == GRP_HW_COMP);
   assign isNone    = (grp == GRP_NONE);
   assign isCsr     = (addr == ADDR_CPU_CONTROL_STATUS_REG);
   assign isSecProt = (addr == ADDR_SEC_PROT);
   assign isClk     = (addr == ADDR_CLK_SEL);
   assign isRng     = (addr == ADDR_RNG_OUT);
   assign isKey     = (addr >= ADDR_KEY_FIRST) && (addr <= ADDR_KEY_LAST);

   // Per-component rights from the firewall and from the segment entry
   assign fwHwOk  = isWr ? fwWrRights[comp] : fwRdRights[comp];
   assign segHwOk = isWr ? segWrRights[comp] : segRdRights[comp];

   // Grants per mode
   assign bootOk = ~isTest & ~isSeg & ~isBanked & ~isNone;
   assign testOk = ~isSeg & ~isBanked & ~isNone;
   assign fwOk   = isShared | (isFwCfg & isRd) | isFwOs
                 | (isHw & fwHwOk)
                 | (isClk & isRd)
                 | (isCsr & isRd);
   assign sysOk  = isShared | isBanked | isSeg | isSys | isFwCfg | isHw;
   assign usrOk  = isShared | isBanked
                 | (isHw & segHwOk)
                 | (isCsr & isRd);

   // Select the grant of the current mode
   assign modeOk = (mode == MODE_BOOT)     ? bootOk :
                   (mode == MODE_TEST)     ? testOk :
                   (mode == MODE_FIRMWARE) ? fwOk   :
                   (mode == MODE_SYSTEM)   ? sysOk  :
                   (mode == MODE_USER)     ? usrOk  : 1'b0;

   // Denials of segmentation and banked access outside their modes, and of register reads or writes closed in every mode
   assign veto = (isSeg & (mode != MODE_SYSTEM))
               | (isBanked & (mode != MODE_SYSTEM) & (mode != MODE_USER))
               | (isSecProt & isRd)
               | (isRng & isWr)
               | (isKey & isRd);

   // Shared registers stay open in every mode unless vetoed
   assign allow = (modeOk | (isShared & ~isNone)) & ~veto;

endmodule : smac_rule_eval
`default_nettype wire

//--- testbench/sfr_mode_access_checker_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sfr_mode_access_checker_tb
   import smac_pkg::*;
;
   logic          mclk, nrst, cpuReq, cpuWr, dmaStart, dmaStop, dmaReq, dmaWr, sfrEn, sfrWr;
   logic          eeIntegrityFn, eeWriteActive, faultClear, eeWholeAccess, eeFwAreaOnly;
   logic          cpuFault, cpuRdValid, dmaGnt, dmaFault, dmaRdValid, dmaBusy;
   logic          faultValid, faultWr, faultFromDma;
   smac_mode_type cpuMode, dmaMode, faultMode;
   logic [7:0]    cpuAddr, cpuWdata, dmaAddr, dmaWdata, segRdRights, segWrRights, sfrRdata;
   logic [7:0]    cpuRdata, dmaRdata, sfrAddr, sfrWdata, faultAddr, fwFirewallCtrlLow;
   logic [7:0]    fwFirewallCtrlHigh, fwLo, fwHi, segLo, segHi;
   logic [15:0]   segTableBase;
   int            err_total, tests_run;
   localparam logic [7:0] ADDRS [15] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h41, 8'h50,
      8'h60, 8'h70, 8'h72, 8'h74, 8'h77, 8'h78, 8'h7A, 8'h80};

   sfr_mode_access_checker u_sfr_mode_access_checker (.mclk(mclk), .nrst(nrst),
      .cpuMode(cpuMode), .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuAddr(cpuAddr),
      .cpuWdata(cpuWdata), .cpuFault(cpuFault), .cpuRdValid(cpuRdValid), .cpuRdata(cpuRdata),
      .dmaStart(dmaStart), .dmaStop(dmaStop), .dmaReq(dmaReq), .dmaWr(dmaWr),
      .dmaAddr(dmaAddr), .dmaWdata(dmaWdata), .dmaGnt(dmaGnt), .dmaFault(dmaFault),
      .dmaRdValid(dmaRdValid), .dmaRdata(dmaRdata), .dmaBusy(dmaBusy), .dmaMode(dmaMode),
      .segRdRights(segRdRights), .segWrRights(segWrRights), .sfrEn(sfrEn), .sfrWr(sfrWr),
      .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
      .segTableBase(segTableBase), .fwFirewallCtrlLow(fwFirewallCtrlLow),
      .fwFirewallCtrlHigh(fwFirewallCtrlHigh), .eeIntegrityFn(eeIntegrityFn),
      .eeWriteActive(eeWriteActive), .eeWholeAccess(eeWholeAccess),
      .eeFwAreaOnly(eeFwAreaOnly), .faultValid(faultValid), .faultAddr(faultAddr),
      .faultWr(faultWr), .faultFromDma(faultFromDma), .faultMode(faultMode),
      .faultClear(faultClear));
   smac_regfile_model u_smac_regfile_model (.mclk(mclk), .sfrEn(sfrEn), .sfrWr(sfrWr),
      .sfrAddr(sfrAddr), .sfrRdata(sfrRdata));

   // Comparison with mismatch report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict();
      if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // Expected grant from mode, direction and address
   function automatic logic exp_ok(input smac_mode_type m, input logic w, input logic [7:0] a);
      logic [2:0] c;
      logic       b;
      logic       s;
      logic       f;
      logic       u;
      c = a[3:1];
      b = (m == MODE_BOOT) || (m == MODE_TEST);
      s = m == MODE_SYSTEM;
      f = m == MODE_FIRMWARE;
      u = m == MODE_USER;
      if (w ? a == ADDR_RNG_OUT : (a == ADDR_SEC_PROT || a inside {[8'h74:8'h77]})) return 0;
      case (a[7:4])
         4'h0: return 1'b1;
         4'h1: return s || u;
         4'h2: return m == MODE_TEST;
         4'h3: return s;
         4'h4: return b || s || (!w && a == ADDR_CPU_CONTROL_STATUS_REG && (f || u));
         4'h5: return b || s || (f && !w);
         4'h6: return b || f;
         4'h7: return b || s || (f && (w ? fwHi[c] : (fwLo[c] || a == ADDR_CLK_SEL)))
                  || (u && (w ? segWrRights[c] : segRdRights[c]));
         default: return 1'b0;
      endcase
   endfunction : exp_ok

   // Expected read value of a granted read
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      case (a)
         ADDR_SEG_BASE_LO: return segLo;
         ADDR_SEG_BASE_HI: return segHi;
         ADDR_FW_CTRL_LO: return fwLo;
         ADDR_FW_CTRL_HI: return fwHi;
         default: return a ^ 8'h5A;
      endcase
   endfunction : exp_rd

   // One CPU access with its decision and read answer checked
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic ok;
      ok = exp_ok(cpuMode, w, a);
      @(negedge mclk);
      {cpuReq, cpuWr, cpuAddr, cpuWdata} = {1'b1, w, a, d};
      #1;
      chk(cpuFault, !ok);
      chk({sfrWr, sfrAddr, sfrWdata}, {w, a, d});
      if (!(a inside {8'h30, 8'h31, 8'h50, 8'h51})) chk(sfrEn, ok);
      @(negedge mclk);
      cpuReq = 1'b0;
      if (!w) chk({cpuRdValid, cpuRdata}, {1'b1, ok ? exp_rd(a) : 8'h00});
   endtask : acc

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Hang guard
   initial begin
      repeat (3000) @(posedge mclk);
      err_total++;
      print_verdict();
   end

   initial begin
      nrst = 1'b0;
      cpuMode = MODE_BOOT;
      {cpuReq, cpuWr, dmaStart, dmaStop, dmaReq, dmaWr, eeIntegrityFn, eeWriteActive} = '0;
      {faultClear, cpuAddr, cpuWdata, dmaAddr, dmaWdata, fwLo, fwHi, segLo, segHi} = '0;
      {segRdRights, segWrRights} = 16'h2010;
      repeat (6) @(negedge mclk);
      nrst = 1'b1;
      chk({segTableBase, fwFirewallCtrlLow}, 24'h00_0000);
      // System mode sets firewall rights and the table address
      cpuMode = MODE_SYSTEM;
      acc(1'b1, ADDR_FW_CTRL_LO, 8'h10);
      acc(1'b1, ADDR_FW_CTRL_HI, 8'h20);
      acc(1'b1, ADDR_SEG_BASE_LO, 8'hC3);
      acc(1'b1, ADDR_SEG_BASE_HI, 8'h12);
      {fwHi, fwLo, segHi, segLo} = 32'h2010_12C3;
      chk({segTableBase, fwFirewallCtrlHigh, fwFirewallCtrlLow}, 32'h12C3_2010);
      // Every mode against every group, reads then same-value writes
      for (int m = 0; m < 5; m++) begin
         cpuMode = smac_mode_type'(m);
         foreach (ADDRS[i]) begin
            acc(1'b0, ADDRS[i], 8'h00);
            acc(1'b1, ADDRS[i], exp_rd(ADDRS[i]));
         end
      end
      // Refused write keeps the table address and is recorded once older faults are cleared
      faultClear = 1'b1;
      @(negedge mclk);
      faultClear = 1'b0;
      cpuMode = MODE_USER;
      acc(1'b1, ADDR_SEG_BASE_LO, 8'hFF);
      chk(segTableBase, 16'h12C3);
      chk({faultValid, faultWr, faultFromDma, faultAddr}, {3'b110, ADDR_SEG_BASE_LO});
      chk(faultMode, MODE_USER);
      faultClear = 1'b1;
      @(negedge mclk);
      faultClear = 1'b0;
      chk(faultValid, 1'b0);
      // Copy engine keeps its start mode after the CPU drops to user
      cpuMode = MODE_SYSTEM;
      dmaStart = 1'b1;
      @(negedge mclk);
      dmaStart = 1'b0;
      cpuMode = MODE_USER;
      chk({dmaBusy, dmaMode}, {1'b1, MODE_SYSTEM});
      dmaAddr = ADDR_SEG_BASE_LO;
      dmaReq = 1'b1;
      #1;
      chk({dmaGnt, dmaFault}, 2'b10);
      @(negedge mclk);
      chk({dmaRdValid, dmaRdata}, {1'b1, segLo});
      // Refused copy engine write is recorded with its latched mode
      {dmaWr, dmaAddr} = {1'b1, 8'h60};
      #1;
      chk({dmaGnt, dmaFault, sfrEn}, 3'b110);
      @(negedge mclk);
      chk({faultValid, faultFromDma, faultWr, faultAddr, faultMode}, {11'h760, MODE_SYSTEM});
      {cpuReq, cpuWr, cpuAddr} = {2'b10, 8'h00};
      #1;
      chk(dmaGnt, 1'b0);
      @(negedge mclk);
      {cpuReq, dmaReq, dmaStop} = 3'b001;
      @(negedge mclk);
      dmaStop = 1'b0;
      chk(dmaBusy, 1'b0);
      // EEPROM reach of firmware functions
      cpuMode = MODE_FIRMWARE;
      {eeIntegrityFn, eeWriteActive} = 2'b11;
      #1;
      chk({eeWholeAccess, eeFwAreaOnly}, 2'b10);
      @(negedge mclk);
      eeWriteActive = 1'b0;
      #1;
      chk({eeWholeAccess, eeFwAreaOnly}, 2'b01);
      // Reset in mid-run clears table address and firewall rights
      @(negedge mclk);
      nrst = 1'b0;
      cpuMode = MODE_SYSTEM;
      #1;
      chk({eeWholeAccess, eeFwAreaOnly}, 2'b00);
      chk({segTableBase, fwFirewallCtrlHigh, fwFirewallCtrlLow}, 32'h0000_0000);
      @(negedge mclk);
      nrst = 1'b1;
      segLo = 8'h00;
      acc(1'b0, ADDR_SEG_BASE_LO, 8'h00);
      print_verdict();
   end
endmodule : sfr_mode_access_checker_tb

bind sfr_mode_access_checker smac_chk u_smac_chk (.mclk(mclk), .nrst(nrst),
   .cpuMode(cpuMode), .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuAddr(cpuAddr),
   .cpuFault(cpuFault), .cpuRdValid(cpuRdValid), .cpuRdata(cpuRdata), .sfrEn(sfrEn),
   .dmaStart(dmaStart), .dmaStop(dmaStop), .dmaReq(dmaReq), .dmaBusy(dmaBusy),
   .dmaGnt(dmaGnt), .dmaMode(dmaMode), .faultValid(faultValid));
`default_nettype wire

//--- testbench/smac_chk.sv
`timescale 1ns/100ps
`default_nettype none
module smac_chk
   import smac_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          nrst,
   input  wire smac_mode_type cpuMode,
   input  wire logic          cpuReq,
   input  wire logic          cpuWr,
   input  wire logic [7:0]    cpuAddr,
   input  wire logic          cpuFault,
   input  wire logic          cpuRdValid,
   input  wire logic [7:0]    cpuRdata,
   input  wire logic          sfrEn,
   input  wire logic          dmaStart,
   input  wire logic          dmaStop,
   input  wire logic          dmaReq,
   input  wire logic          dmaBusy,
   input  wire logic          dmaGnt,
   input  wire smac_mode_type dmaMode,
   input  wire logic          faultValid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Decisions in the request cycle
   property p_seg; cpuReq && cpuAddr[7:4] == 4'h3 && cpuMode != MODE_SYSTEM |-> cpuFault; endproperty
   a_seg: assert property (p_seg) else $error("segment cfg access not refused");
   property p_shared; cpuReq && cpuAddr[7:4] == 4'h0 |-> !cpuFault && sfrEn; endproperty
   a_shared: assert property (p_shared) else $error("shared cpu access refused");
   property p_bank; cpuReq && cpuAddr[7:4] == 4'h1 |-> cpuFault == (cpuMode < MODE_SYSTEM); endproperty
   a_bank: assert property (p_bank) else $error("banked access decided wrongly");
   property p_sec; cpuReq && !cpuWr && cpuAddr == ADDR_SEC_PROT |-> cpuFault; endproperty
   a_sec: assert property (p_sec) else $error("protection setting read");
   property p_rng; cpuReq && cpuWr && cpuAddr == ADDR_RNG_OUT |-> cpuFault; endproperty
   a_rng: assert property (p_rng) else $error("random output written");
   property p_key; cpuReq && !cpuWr && cpuAddr inside {[ADDR_KEY_FIRST:ADDR_KEY_LAST]} |-> cpuFault; endproperty
   a_key: assert property (p_key) else $error("key register read");
   property p_noen; cpuFault |-> !sfrEn; endproperty
   a_noen: assert property (p_noen) else $error("refused access reached register file");
   // Read answers and fault record
   property p_rdzero; cpuReq && !cpuWr && cpuFault |=> cpuRdValid && cpuRdata == 8'h00; endproperty
   a_rdzero: assert property (p_rdzero) else $error("refused read returned data");
   property p_frec; cpuFault |=> faultValid; endproperty
   a_frec: assert property (p_frec) else $error("fault not recorded");
   // Copy engine arbitration and latched mode
   property p_gnt; dmaGnt |-> dmaReq && dmaBusy && !cpuReq; endproperty
   a_gnt: assert property (p_gnt) else $error("copy engine granted wrongly");
   property p_dmode; dmaBusy && !dmaStart && !dmaStop |=> $stable(dmaMode); endproperty
   a_dmode: assert property (p_dmode) else $error("copy engine mode changed");
endmodule : smac_chk
`default_nettype wire

//--- testbench/smac_regfile_model.sv
`timescale 1ns/100ps
`default_nettype none
module smac_regfile_model (
   input  wire logic       mclk,
   input  wire logic       sfrEn,
   input  wire logic       sfrWr,
   input  wire logic [7:0] sfrAddr,
   output logic [7:0]      sfrRdata
);
   logic [7:0] noise_reg = 8'h96;
   // Unselected read bus shows a pattern that changes every cycle
   always @(posedge mclk) begin
      noise_reg <= ~noise_reg ^ 8'h3C;
   end
   // Register contents follow the address so reads are predictable
   assign sfrRdata = (sfrEn && !sfrWr) ? (sfrAddr ^ 8'h5A) : noise_reg;
endmodule : smac_regfile_model
`default_nettype wire
